// ===== common/tile_pkg.sv
// Purpose: Types shared by the tile status register bank
// Assumes: None
// Notes:   Constants live in tile_regs.svh
package tile_pkg;
   // Processor status request, one cycle wide
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } ps_req_s;
endpackage : tile_pkg

// ===== common/tile_regs.svh
// Purpose: Offsets, masks and field positions of the tile status registers
// Assumes: Processor status accesses carry an 8-bit register number
// Notes:   Definitions only
//
// Behaviour
// RULE_01 - Transmit data delay field, reset zero
// RULE_02 - Divider counter sets and clears transmit clock
// RULE_03 - Software writes divide ratio minus one
// RULE_04 - Enable bit connects RGMII to ports
// RULE_05 - Dynamic mode divides only while threads paused
// RULE_06 - Bit four enables low-power clock divider
// RULE_07 - Bit two selects UTMI, else ULPI
// RULE_08 - Bit one enables ULPI support module
// RULE_09 - Boot status read-only, processor number field
// RULE_10 - Boot status flags RAM and JTAG boot
// RULE_11 - Boot status shows sampled PLL mode pins
// RULE_12 - Boot status bit five: second core powered
// RULE_13 - Security word loaded from OTP
// RULE_14 - Bit thirty-one set refuses security writes
// RULE_15 - Bit fourteen blocks global debug
// RULE_16 - Bit zero blocks JTAG debug port
// RULE_17 - Master and per-sector OTP lock bits
// RULE_18 - OTP boot override; PLL JTAG block
// RULE_19 - Four free-running oscillators drive own counters
// RULE_20 - Control bits start core and peripheral oscillators
// RULE_21 - Read counters after ten stopped cycles
// RULE_22 - 16-bit counts survive system reset
// RULE_23 - Reached only by processor status accesses
// RULE_24 - Reserved bits read zero, ignore writes
`ifndef TILE_REGS_SVH
`define TILE_REGS_SVH

// ****************************************
// Register numbers
// ****************************************
`define OFF_TILE_CTRL   8'h02
`define OFF_BOOT_STAT   8'h03
`define OFF_SEC_CFG     8'h05
`define OFF_OSC_CTRL    8'h06
`define OFF_OSC_CELL    8'h07
`define OFF_OSC_WIRE    8'h08

// ****************************************
// Writable bit masks and reset values
// ****************************************
`define MASK_TILE_CTRL  32'h03FF_FF36
`define MASK_SEC_CFG    32'h8000_5FB1
`define MASK_OSC_CTRL   32'h0000_0003
`define RST_WORD        32'h0000_0000
`define RST_CNT         16'h0000

// ****************************************
// Field positions
// ****************************************
`define TC_DELAY        25:18
`define TC_DIV          17:9
`define TC_RGMII_EN     8
`define TC_DYN          5
`define TC_LP_EN        4
`define TC_UTMI         2
`define TC_ULPI_EN      1
`define SC_LOCK         31
`define SC_GDBG         14
`define SC_OTP_ALL      12
`define SC_OTP_SECT     11:8
`define SC_OTP_RED      7
`define SC_OTP_BOOT     5
`define SC_PLL_JTAG     4
`define SC_JTAG_TAP     0
`define OC_CORE         1
`define OC_PERIPH       0

`endif

// ===== src/tile_control_status_regs.sv
// Purpose: Processor status register bank of one tile
// Assumes: clock_i is the PLL output at 50 MHz
// Notes:   Ring oscillator ticks arrive from free-running cells
`timescale 1ns/1ps
`default_nettype none
`include "tile_regs.svh"

module tile_control_status_regs
   import tile_pkg::*;
#(
   parameter int OSC_N   = 4,
   parameter int CNT_W   = 16
) (
   // Clock and resets
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   input  wire logic              por_arst_n_i,
   // Processor status access
   input  wire ps_req_s           ps_req_i,
   output logic [31:0]            ps_rdata_o,
   output logic                   ps_ack_o,
   output logic                   ps_err_o,
   // Boot status sources
   input  wire logic [7:0]        proc_num_i,
   input  wire logic              boot_from_ram_i,
   input  wire logic              boot_from_jtag_i,
   input  wire logic [1:0]        pll_mode_pin_value_i,
   input  wire logic              second_core_powered_i,
   input  wire logic              otp_no_poll_i,
   // OTP security word load
   input  wire logic              otp_load_i,
   input  wire logic [31:0]       otp_word_i,
   // Thread state and oscillator ticks
   input  wire logic              threads_paused_i,
   input  wire logic [OSC_N-1:0]  osc_tick_i,
   // RGMII, low-power divider and USB controls
   output logic                   rgmii_txclk_o,
   output logic [7:0]             rgmii_tx_delay_o,
   output logic                   rgmii_ports_connect_o,
   output logic                   lp_divide_active_o,
   output logic                   utmi_select_o,
   output logic                   ulpi_module_enable_o,
   // Security controls
   output logic                   global_debug_block_o,
   output logic                   jtag_tap_block_o,
   output logic                   otp_master_lock_o,
   output logic [3:0]             otp_sector_lock_o,
   output logic                   otp_redundancy_o,
   output logic                   boot_from_otp_o,
   output logic                   pll_jtag_block_o
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [31:0]       tile_ctrl_ff;
   logic [31:0]       sec_cfg_ff;
   logic [31:0]       osc_ctrl_ff;
   logic [31:0]       boot_stat_ff;
   logic [8:0]        div_cnt_ff;
   logic [1:0]        pin_s1_ff;
   logic [1:0]        pin_s2_ff;
   logic [OSC_N-1:0]  tick_s1_ff;
   logic [OSC_N-1:0]  tick_s2_ff;
   logic [OSC_N-1:0]  tick_s3_ff;
   logic [CNT_W-1:0]  osc_cnt_ff [OSC_N];
   logic [31:0]       nxt_rdata;
   logic              nxt_err;
   logic              wr_ctrl;
   logic              wr_sec;
   logic              wr_osc;
   logic [8:0]        div_val;

   // Write strobes per register
   assign wr_ctrl = ps_req_i.wr && (ps_req_i.addr == `OFF_TILE_CTRL);
   assign wr_sec  = ps_req_i.wr && (ps_req_i.addr == `OFF_SEC_CFG);
   assign wr_osc  = ps_req_i.wr && (ps_req_i.addr == `OFF_OSC_CTRL);
   assign div_val = tile_ctrl_ff[`TC_DIV];

   // ****************************************
   // Tile control register
   // ****************************************

   // Writable fields only, reserved bits stay zero
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tile_ctrl_ff <= `RST_WORD;
      end else if (wr_ctrl) begin
         tile_ctrl_ff <= ps_req_i.wdata & `MASK_TILE_CTRL; // [RULE_24] [RULE_01]
      end
   end

   // Static controls presented from flops
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rgmii_tx_delay_o      <= 8'h00;
         rgmii_ports_connect_o <= 1'b0;
         utmi_select_o         <= 1'b0;
         ulpi_module_enable_o  <= 1'b0;
      end else begin
         rgmii_tx_delay_o      <= tile_ctrl_ff[`TC_DELAY];    // [RULE_01]
         rgmii_ports_connect_o <= tile_ctrl_ff[`TC_RGMII_EN]; // [RULE_04]
         utmi_select_o         <= tile_ctrl_ff[`TC_UTMI];     // [RULE_07]
         ulpi_module_enable_o  <= tile_ctrl_ff[`TC_ULPI_EN];  // [RULE_08]
      end
   end

   // Low-power divider gate: static, or only while threads are paused
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_divide_active_o <= 1'b0;
      end else begin
         lp_divide_active_o <= tile_ctrl_ff[`TC_LP_EN] &&
            (!tile_ctrl_ff[`TC_DYN] || threads_paused_i); // [RULE_05] [RULE_06]
      end
   end

   // ****************************************
   // RGMII transmit clock divider
   // ****************************************

   // Counter wraps after the programmed ratio minus one
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt_ff <= 9'h000;
      end else if (div_cnt_ff >= div_val) begin
         div_cnt_ff <= 9'h000; // [RULE_03]
      end else begin
         div_cnt_ff <= div_cnt_ff + 9'h001;
      end
   end

   // Rise at the divider value, fall at half of it
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rgmii_txclk_o <= 1'b0;
      end else if (div_cnt_ff == div_val) begin
         rgmii_txclk_o <= 1'b1; // [RULE_02]
      end else if (div_cnt_ff == (div_val >> 1)) begin
         rgmii_txclk_o <= 1'b0; // [RULE_02]
      end
   end

   // ****************************************
   // Boot status
   // ****************************************

   // Mode pins cross in through two flops
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_ff <= 2'b00;
         pin_s2_ff <= 2'b00;
      end else begin
         pin_s1_ff <= pll_mode_pin_value_i;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // Read-only image rebuilt every cycle
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_stat_ff <= `RST_WORD;
      end else begin
         boot_stat_ff <= {8'h00, proc_num_i, 7'h00,      // [RULE_09]
                          sec_cfg_ff[`SC_OTP_BOOT], 2'b00,
                          second_core_powered_i,          // [RULE_12]
                          otp_no_poll_i,
                          boot_from_ram_i, boot_from_jtag_i, // [RULE_10]
                          pin_s2_ff};                     // [RULE_11]
      end
   end

   // ****************************************
   // Security configuration
   // ****************************************

   // OTP load always lands; software writes only while unlocked
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sec_cfg_ff <= `RST_WORD;
      end else if (otp_load_i) begin
         sec_cfg_ff <= otp_word_i & `MASK_SEC_CFG; // [RULE_13]
      end else if (wr_sec && !sec_cfg_ff[`SC_LOCK]) begin
         sec_cfg_ff <= ps_req_i.wdata & `MASK_SEC_CFG; // [RULE_14]
      end
   end

   // Security controls presented from flops
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         global_debug_block_o <= 1'b0;
         jtag_tap_block_o     <= 1'b0;
         otp_master_lock_o    <= 1'b0;
         otp_sector_lock_o    <= 4'h0;
         otp_redundancy_o     <= 1'b0;
         boot_from_otp_o      <= 1'b0;
         pll_jtag_block_o     <= 1'b0;
      end else begin
         global_debug_block_o <= sec_cfg_ff[`SC_GDBG];     // [RULE_15]
         jtag_tap_block_o     <= sec_cfg_ff[`SC_JTAG_TAP]; // [RULE_16]
         otp_master_lock_o    <= sec_cfg_ff[`SC_OTP_ALL];  // [RULE_17]
         otp_sector_lock_o    <= sec_cfg_ff[`SC_OTP_SECT]; // [RULE_17]
         otp_redundancy_o     <= sec_cfg_ff[`SC_OTP_RED];
         boot_from_otp_o      <= sec_cfg_ff[`SC_OTP_BOOT]; // [RULE_18]
         pll_jtag_block_o     <= sec_cfg_ff[`SC_PLL_JTAG]; // [RULE_18]
      end
   end

   // ****************************************
   // Ring oscillators
   // ****************************************

   // Run bits for core and peripheral groups
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_ctrl_ff <= `RST_WORD;
      end else if (wr_osc) begin
         osc_ctrl_ff <= ps_req_i.wdata & `MASK_OSC_CTRL; // [RULE_20]
      end
   end

   // Ticks cross in; third flop feeds the edge detector
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_s1_ff <= '0;
         tick_s2_ff <= '0;
         tick_s3_ff <= '0;
      end else begin
         tick_s1_ff <= osc_tick_i;
         tick_s2_ff <= tick_s1_ff;
         tick_s3_ff <= tick_s2_ff;
      end
   end

   // One counter per oscillator, cleared only at power-on
   for (genvar g = 0; g < OSC_N; g++) begin : g_osc
      logic run;
      assign run = (g < 2) ? osc_ctrl_ff[`OC_CORE] : osc_ctrl_ff[`OC_PERIPH];
      always_ff @(posedge clock_i or negedge por_arst_n_i) begin
         if (!por_arst_n_i) begin
            osc_cnt_ff[g] <= `RST_CNT; // [RULE_22]
         end else if (run && tick_s2_ff[g] && !tick_s3_ff[g]) begin
            osc_cnt_ff[g] <= osc_cnt_ff[g] + 16'h0001; // [RULE_19]
         end
      end
   end

   // ****************************************
   // Read path and answer
   // ****************************************

   // Register number decode for reads
   always_comb begin
      nxt_rdata = `RST_WORD;
      nxt_err   = 1'b0;
      if (ps_req_i.addr == `OFF_TILE_CTRL) begin
         nxt_rdata = tile_ctrl_ff;
      end else if (ps_req_i.addr == `OFF_BOOT_STAT) begin
         nxt_rdata = boot_stat_ff;
      end else if (ps_req_i.addr == `OFF_SEC_CFG) begin
         nxt_rdata = sec_cfg_ff;
         nxt_err   = ps_req_i.wr && sec_cfg_ff[`SC_LOCK]; // [RULE_14]
      end else if (ps_req_i.addr == `OFF_OSC_CTRL) begin
         nxt_rdata = osc_ctrl_ff;
      end else if (ps_req_i.addr == `OFF_OSC_CELL) begin
         nxt_rdata = {16'h0000, osc_cnt_ff[0]}; // [RULE_22] [RULE_24]
      end else if (ps_req_i.addr == `OFF_OSC_WIRE) begin
         nxt_rdata = {16'h0000, osc_cnt_ff[1]}; // [RULE_22]
      end else begin
         nxt_err   = 1'b1; // [RULE_24]
      end
   end

   // Answer one cycle after the access
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ps_rdata_o <= `RST_WORD;
         ps_ack_o   <= 1'b0;
         ps_err_o   <= 1'b0;
      end else begin
         ps_ack_o   <= ps_req_i.wr || ps_req_i.rd; // [RULE_23]
         ps_err_o   <= (ps_req_i.wr || ps_req_i.rd) && nxt_err;
         ps_rdata_o <= ps_req_i.rd ? nxt_rdata : `RST_WORD;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_delay_field: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_01]
      wr_ctrl |-> ##2 rgmii_tx_delay_o == $past(ps_req_i.wdata[`TC_DELAY], 2))
      else $error("Transmit delay not taken from write");

   a_txclk_rise: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_02]
      div_cnt_ff == div_val |=> rgmii_txclk_o)
      else $error("Transmit clock did not rise");

   a_txclk_fall: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_02]
      (div_cnt_ff == (div_val >> 1)) && (div_cnt_ff != div_val) |=> !rgmii_txclk_o)
      else $error("Transmit clock did not fall");

   a_sec_locked: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_14]
      wr_sec && sec_cfg_ff[`SC_LOCK] && !otp_load_i |=> $stable(sec_cfg_ff) && ps_err_o)
      else $error("Locked security word changed");

   a_lp_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_05]
      tile_ctrl_ff[`TC_LP_EN] && tile_ctrl_ff[`TC_DYN] && !threads_paused_i
      |=> !lp_divide_active_o)
      else $error("Dynamic divider active with running threads");

   a_osc_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_20]
      !osc_ctrl_ff[`OC_CORE] [*4] |=> $stable(osc_cnt_ff[0]))
      else $error("Stopped oscillator count moved");

   a_boot_bits: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_10]
      1'b1 |=> boot_stat_ff[3:2] == $past({boot_from_ram_i, boot_from_jtag_i})
               && boot_stat_ff[1:0] == $past(pin_s2_ff))
      else $error("Boot status bits wrong");

   a_unmapped: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_24]
      ps_req_i.rd && ps_req_i.addr > `OFF_OSC_WIRE |=> ps_ack_o && ps_err_o && ps_rdata_o == 32'h0000_0000)
      else $error("Unmapped read answered wrongly");

   a_usb_select: assert property (@(posedge clock_i) disable iff (!arst_n_i) // [RULE_07]
      wr_ctrl |-> ##2 utmi_select_o == $past(ps_req_i.wdata[`TC_UTMI], 2))
      else $error("Transceiver style not applied");

endmodule : tile_control_status_regs
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the tile status register bank
// Assumes: Inputs change on the falling clock edge
// Notes:   Table loop for tile control, hand-written cases after it
`timescale 1ns/1ps
`default_nettype none
`include "tile_regs.svh"

module testbench
   import tile_pkg::*;
;
   // ****
   // Stimulus and observed signals
   // ****
   logic        clk, arst_n, por_n, paused, ram, jtag, core_on, nopoll, ld;
   logic [7:0]  proc;
   logic [1:0]  pins;
   logic [3:0]  tick;
   logic [31:0] otp_w, q, rdata;
   ps_req_s     req;
   logic        ack, err, txclk, conn, lp, utmi, ulpi, gdbg, tap, mlock, red, botp, pllj;
   logic [7:0]  dly;
   logic [3:0]  slock;
   int          errors, checks_done;
   // Tile control rows: written word, paused level, read-back, divider activity
   logic [31:0] row_wd [4] = '{32'hFFFF_FFFF, 32'h0000_0010, 32'h0000_0030, 32'h0000_0126};
   logic [31:0] row_rd [4] = '{32'h03FF_FF36, 32'h0000_0010, 32'h0000_0030, 32'h0000_0126};
   logic        row_p  [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic        row_lp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   tile_control_status_regs dut_u (
      .clock_i(clk), .arst_n_i(arst_n), .por_arst_n_i(por_n),
      .ps_req_i(req), .ps_rdata_o(rdata), .ps_ack_o(ack), .ps_err_o(err),
      .proc_num_i(proc), .boot_from_ram_i(ram), .boot_from_jtag_i(jtag),
      .pll_mode_pin_value_i(pins), .second_core_powered_i(core_on), .otp_no_poll_i(nopoll),
      .otp_load_i(ld), .otp_word_i(otp_w), .threads_paused_i(paused), .osc_tick_i(tick),
      .rgmii_txclk_o(txclk), .rgmii_tx_delay_o(dly), .rgmii_ports_connect_o(conn),
      .lp_divide_active_o(lp), .utmi_select_o(utmi), .ulpi_module_enable_o(ulpi),
      .global_debug_block_o(gdbg), .jtag_tap_block_o(tap), .otp_master_lock_o(mlock),
      .otp_sector_lock_o(slock), .otp_redundancy_o(red), .boot_from_otp_o(botp),
      .pll_jtag_block_o(pllj)
   );

   // ****
   // Helpers
   // ****
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // One processor status access, then wait for the answer pulse
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
      int n;
      @(negedge clk);
      req = '{w, !w, a, d};
      @(negedge clk);
      req = '0;
      for (n = 0; n < 3 && ack !== 1'b1; n++) @(negedge clk);
      chk("ack", 1, ack);
      chk("err", xe, err);
      q = rdata;
   endtask : acc

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
      acc(1'b0, a, 32'h0000_0000, 1'b0);
      chk(nm, x, q);
   endtask : rd

   task automatic rst_pulse();
      @(negedge clk);
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
   endtask : rst_pulse

   task automatic ticks(input logic [3:0] m, input int n);
      repeat (n) begin
         @(negedge clk);
         tick = m;
         repeat (4) @(negedge clk);
         tick = 4'h0;
         repeat (3) @(negedge clk);
      end
   endtask : ticks

   // Measure transmit clock period and high time over 40 samples
   task automatic txm(input int per, input int hi);
      logic s [40];
      int i, j, h;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         s[i] = txclk;
      end
      i = 1;
      while (i < 38 && !(s[i] && !s[i-1])) i++;
      j = i + 1;
      while (j < 39 && !(s[j] && !s[j-1])) j++;
      h = 0;
      for (int k = i; k < j; k++) h += s[k];
      chk("txclk period", per, j - i);
      chk("txclk high", hi, h);
   endtask : txm

   function automatic logic [9:0] sec_x(input logic [31:0] w);
      return {w[14], w[0], w[12], w[11:8], w[7], w[5], w[4]};
   endfunction : sec_x

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // ****
   // Clock and watchdog
   // ****
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end

   // ****
   // Main sequence
   // ****
   initial begin
      {arst_n, por_n, paused, ram, jtag, core_on, nopoll, ld} = '0;
      {proc, pins, tick, otp_w} = '0;
      req = '0;
      errors = 0;
      checks_done = 0;
      repeat (8) @(negedge clk);
      chk("outs in reset", 0, {ack, err, txclk, conn, lp, utmi, ulpi, dly,
          gdbg, tap, mlock, slock, red, botp, pllj});
      chk("rdata in reset", 0, rdata);
      {arst_n, por_n} = 2'b11;
      rd(`OFF_TILE_CTRL, 0, "tile ctrl reset");
      rd(`OFF_OSC_CTRL, 0, "osc ctrl reset");
      // Table of tile control writes
      for (int r = 0; r < 4; r++) begin
         paused = row_p[r];
         acc(1'b1, `OFF_TILE_CTRL, row_wd[r], 1'b0);
         repeat (3) @(negedge clk);
         rd(`OFF_TILE_CTRL, row_rd[r], "tile ctrl");
         chk("tile outs", {row_rd[r][25:18], row_rd[r][8], row_rd[r][2], row_rd[r][1]},
             {dly, conn, utmi, ulpi});
         chk("lp divide", row_lp[r], lp);
      end
      // Transmit clock divider: ratio five, ratio two, then a zero divider field (clock held high)
      rst_pulse();
      acc(1'b1, `OFF_TILE_CTRL, 32'h0000_0800, 1'b0);
      txm(5, 3);
      rst_pulse();
      acc(1'b1, `OFF_TILE_CTRL, 32'h0000_0200, 1'b0);
      txm(2, 1);
      acc(1'b1, `OFF_TILE_CTRL, 32'h0000_0000, 1'b0);
      repeat (4) @(negedge clk);
      repeat (5) begin
         @(negedge clk);
         chk("txclk div0", 1, txclk);
      end
      // Security word: OTP load, writes, lock
      @(negedge clk);
      ld = 1'b1;
      otp_w = 32'h7FFF_FFFF;
      @(negedge clk);
      ld = 1'b0;
      repeat (3) @(negedge clk);
      rd(`OFF_SEC_CFG, 32'h0000_5FB1, "sec load");
      chk("sec outs", sec_x(32'h0000_5FB1), {gdbg, tap, mlock, slock, red, botp, pllj});
      acc(1'b1, `OFF_SEC_CFG, 32'h0000_0000, 1'b0);
      repeat (3) @(negedge clk);
      chk("sec clear", 0, {gdbg, tap, mlock, slock, red, botp, pllj});
      acc(1'b1, `OFF_SEC_CFG, 32'h8000_0021, 1'b0);
      acc(1'b1, `OFF_SEC_CFG, 32'h0000_0000, 1'b1);
      rd(`OFF_SEC_CFG, 32'h8000_0021, "sec locked");
      chk("sec lock outs", sec_x(32'h8000_0021), {gdbg, tap, mlock, slock, red, botp, pllj});
      // Boot status with two opposite input patterns
      {proc, ram, jtag, pins, core_on, nopoll} = {8'hA5, 1'b1, 1'b0, 2'b10, 1'b1, 1'b1};
      repeat (5) @(negedge clk);
      rd(`OFF_BOOT_STAT, 32'h00A5_013A, "boot status a");
      acc(1'b1, `OFF_BOOT_STAT, 32'hFFFF_FFFF, 1'b0);
      rst_pulse();
      {proc, ram, jtag, pins, core_on, nopoll} = {8'h5A, 1'b0, 1'b1, 2'b01, 1'b0, 1'b0};
      repeat (5) @(negedge clk);
      rd(`OFF_BOOT_STAT, 32'h005A_0005, "boot status b");
      acc(1'b0, 8'h04, 32'h0000_0000, 1'b1);
      chk("unmapped data", 0, q);
      acc(1'b0, 8'h0C, 32'h0000_0000, 1'b1);
      chk("outside data", 0, q);
      // Oscillator counters: core run counts, peripheral run leaves them alone
      acc(1'b1, `OFF_OSC_CTRL, 32'hFFFF_FFFE, 1'b0);
      rd(`OFF_OSC_CTRL, 32'h0000_0002, "osc ctrl");
      ticks(4'h3, 5);
      ticks(4'h1, 2);
      repeat (4) @(negedge clk);
      acc(1'b1, `OFF_OSC_CTRL, 32'h0000_0001, 1'b0);
      repeat (10) @(negedge clk);
      rd(`OFF_OSC_CELL, 7, "cell count");
      rd(`OFF_OSC_WIRE, 5, "wire count");
      ticks(4'hF, 3);
      acc(1'b1, `OFF_OSC_CTRL, 32'h0000_0000, 1'b0);
      repeat (10) @(negedge clk);
      rst_pulse();
      rd(`OFF_OSC_CELL, 7, "cell after reset");
      rd(`OFF_OSC_WIRE, 5, "wire after reset");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
